// *** common/sac_regs.svh ***
// Operation
// - Bit 7 selects request; low seven give operation
// - Bit 7 sets or clears request at completion
// - Word push duplicates head, drops bottom, 16 cycles
// - Pi push shifts 32-bit stack, 16 cycles
// - Power: second raised to head, stack up
// - Power with nonpositive base reports error 0100
// - Power exponent of magnitude 32 or more reports 1100
// - Add: carry flag, overflow keeps low 16 bits
// - Divide: quotient only; 94 or 14 cycles
// - Zero divisor returns dividend, divide error flagged
// - Sine replaces head, keeps B, 30 if tiny
// - Low multiply flags overflow on nonzero upper half
// - High multiply keeps upper half, 98 cycles
// - Most negative operand returned, overflow set
// - Subtract: borrow on carry bit, 32 cycles
// - Subtract overflow on minimum subtrahend or range
// - Tangent replaces head; overflow near first two odd half-pi points
// - Tiny tangent angle returns angle in 30 cycles
// - Add and subtract update sign, zero, carry, error
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH

// Operation codes in the low seven command bits
`define SAC_OPC_NOP 7'h00
`define SAC_OPC_PUSHW 7'h77
`define SAC_OPC_PUSHPI 7'h1a
`define SAC_OPC_POW 7'h0b
`define SAC_OPC_ADD 7'h6c
`define SAC_OPC_SUB 7'h6d
`define SAC_OPC_MULL 7'h6e
`define SAC_OPC_MULU 7'h76
`define SAC_OPC_DIV 7'h6f
`define SAC_OPC_SIN 7'h02
`define SAC_OPC_TAN 7'h04
`define SAC_CMD_SR 7

// Status byte fields
`define SAC_ST_SIGN 7
`define SAC_ST_ZERO 6
`define SAC_ST_ERR_HI 4
`define SAC_ST_ERR_LO 1
`define SAC_ST_CARRY 0

// Error field codes
`define SAC_ERR_NONE 4'h0
`define SAC_ERR_NEG 4'h4
`define SAC_ERR_RANGE 4'hc
`define SAC_ERR_DIV0 4'h8
`define SAC_ERR_OVF 4'h6

// Execution cycle counts
`define SAC_CYC_NOP 14'h0004
`define SAC_CYC_PUSHW 14'h0010
`define SAC_CYC_PUSHPI 14'h0010
`define SAC_CYC_ADD 14'h0012
`define SAC_CYC_SUB 14'h0020
`define SAC_CYC_MULL 14'h005e
`define SAC_CYC_MULU 14'h0062
`define SAC_CYC_DIV 14'h005e
`define SAC_CYC_DIV0 14'h000e
`define SAC_CYC_TINY 14'h001e
`define SAC_CYC_POW 14'h2f00
`define SAC_CYC_SIN 14'h12c8
`define SAC_CYC_TAN 14'h16fe

// Float constants and thresholds
`define SAC_FP_PI 32'h40490fdb
`define SAC_FP_HALF_PI 32'h3fc90fdb
`define SAC_FP_3HALF_PI 32'h4096cbe4
`define SAC_FP_ONE 32'h3f800000
`define SAC_FP_TINY_EXP 8'h73
`define SAC_FP_POW_EXP 8'h84
`define SAC_INT_MIN 16'h8000

`endif

// *** common/sac_pkg.sv ***
package sac_pkg;

	// Decoded operations
	typedef enum logic [3:0] {
		SAC_OP_NOP,
		SAC_OP_PUSHW,
		SAC_OP_PUSHPI,
		SAC_OP_POW,
		SAC_OP_ADD,
		SAC_OP_SUB,
		SAC_OP_MULL,
		SAC_OP_MULU,
		SAC_OP_DIV,
		SAC_OP_SIN,
		SAC_OP_TAN,
		SAC_OP_OTHER
	} sac_op_type;

	// Sequencer states
	typedef enum logic {
		SAC_IDLE,
		SAC_BUSY
	} sac_state_type;

endpackage

// *** hw/sac_int_unit.sv ***
`timescale 1ns/1ps
`include "sac_regs.svh"

module sac_int_unit (
	// Operands: a is the head, b the second word
	input wire logic [15:0] a_in,
	input wire logic [15:0] b_in,
	input wire sac_pkg::sac_op_type op_in,
	// Result and flags
	output logic [15:0] r_out,
	output logic carry_out,
	output logic ovf_out,
	output logic dz_out
);
	logic [16:0] sum_w;
	logic [16:0] dif_w;
	logic signed [31:0] prod_w;
	logic [15:0] quo_w;
	logic min_w;

	// Arithmetic on the two top words
	assign sum_w = {1'h0, b_in} + {1'h0, a_in};
	assign dif_w = {1'h0, b_in} - {1'h0, a_in};
	assign prod_w = $signed(a_in) * $signed(b_in);
	assign dz_out = (a_in == 16'h0000);
	// Zero divisor still reaches the divider, but the dividend is selected in place of its quotient
	assign quo_w = dz_out ? b_in :
		16'($signed(b_in) / $signed(a_in));
	assign min_w = (a_in == `SAC_INT_MIN) || (b_in == `SAC_INT_MIN);

	// Result selection
	always_comb begin
		r_out = 16'h0000;
		carry_out = 1'h0;
		ovf_out = 1'h0;
		unique case (op_in)
			sac_pkg::SAC_OP_ADD: begin
				r_out = sum_w[15:0];
				carry_out = sum_w[16];
				ovf_out = (a_in[15] == b_in[15]) &&
					(sum_w[15] != a_in[15]);
			end
			sac_pkg::SAC_OP_SUB: begin
				r_out = dif_w[15:0];
				carry_out = dif_w[16];
				ovf_out = (a_in == `SAC_INT_MIN) ||
					((a_in[15] != b_in[15]) &&
					(dif_w[15] != b_in[15]));
			end
			sac_pkg::SAC_OP_MULL: begin
				r_out = min_w ? `SAC_INT_MIN : prod_w[15:0];
				ovf_out = min_w || (prod_w[31:16] != 16'h0000);
			end
			sac_pkg::SAC_OP_MULU: begin
				r_out = min_w ? `SAC_INT_MIN : prod_w[31:16];
				ovf_out = min_w;
			end
			sac_pkg::SAC_OP_DIV: begin
				r_out = quo_w;
			end
			default: begin
				r_out = 16'h0000;
			end
		endcase
	end
endmodule // sac_int_unit

// *** hw/sac_flt_unit.sv ***
`timescale 1ns/1ps
`include "sac_regs.svh"

module sac_flt_unit (
	// Operands: a at the head, b below it
	input wire logic [31:0] a_in,
	input wire logic [31:0] b_in,
	input wire sac_pkg::sac_op_type op_in,
	// Result, error code and tiny-angle flag
	output logic [31:0] r_out,
	output logic [3:0] err_out,
	output logic tiny_out
);
	logic b_nonpos_w;
	logic a_big_w;
	logic near_pole_w;

	// Operand classification
	assign tiny_out = (a_in[30:23] < `SAC_FP_TINY_EXP);
	assign b_nonpos_w = b_in[31] || (b_in[30:23] == 8'h00);
	// Coarse bound on the exponent term, it ignores the size of ln B
	assign a_big_w = (a_in[30:23] >= `SAC_FP_POW_EXP);
	// Only the first two odd half-pi points are caught
	assign near_pole_w = (a_in[30:8] == 23'(`SAC_FP_HALF_PI >> 8)) ||
		(a_in[30:8] == 23'(`SAC_FP_3HALF_PI >> 8));

	// Special-case results; general sine and tangent values pass A through, power passes B
	always_comb begin
		r_out = a_in;
		err_out = `SAC_ERR_NONE;
		unique case (op_in)
			sac_pkg::SAC_OP_POW: begin
				if (b_nonpos_w) begin
					err_out = `SAC_ERR_NEG;
					r_out = b_in;
				end else if (a_big_w) begin
					err_out = `SAC_ERR_RANGE;
					r_out = b_in;
				end else begin
					r_out = (a_in[30:23] == 8'h00) ? `SAC_FP_ONE : b_in;
				end
			end
			sac_pkg::SAC_OP_TAN: begin
				r_out = a_in;
				err_out = (!tiny_out && near_pole_w) ? `SAC_ERR_OVF :
					`SAC_ERR_NONE;
			end
			default: begin
				r_out = a_in;
			end
		endcase
	end
endmodule // sac_flt_unit

// *** hw/sac_core.sv ***
`timescale 1ns/1ps
`include "sac_regs.svh"

module sac_core #(
	parameter logic [13:0] POW_CYCLES = `SAC_CYC_POW,
	parameter logic [13:0] SIN_CYCLES = `SAC_CYC_SIN,
	parameter logic [13:0] TAN_CYCLES = `SAC_CYC_TAN
) (
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Command and operand entry
	input wire logic cmd_valid_in,
	input wire logic [7:0] cmd_in,
	input wire logic word_valid_in,
	input wire logic [15:0] word_in,
	// State seen by the host
	output logic cmd_ready_out,
	output logic busy_out,
	output logic [15:0] stack_head_out,
	output logic [15:0] stack_second_out,
	output logic [7:0] status_out,
	output logic svc_req_out
);
	sac_pkg::sac_state_type state_reg;
	sac_pkg::sac_op_type op_reg;
	sac_pkg::sac_op_type dec_op;
	logic [15:0] stk_reg [0:7];
	logic [15:0] stk_next [0:7];
	logic [13:0] cnt_reg;
	logic [13:0] dec_cyc;
	logic sr_reg;
	logic [7:0] status_reg;
	logic [7:0] status_next;
	logic svc_reg;
	logic ready_reg;
	logic busy_reg;
	logic take_w;
	logic push_w;
	logic commit_w;
	logic [6:0] op7_w;
	logic [15:0] int_r;
	logic int_carry;
	logic int_ovf;
	logic int_dz;
	logic [31:0] flt_r;
	logic [3:0] flt_err;
	logic flt_tiny;
	logic [15:0] res_hi_w;
	logic [15:0] res_lo_w;

	// Handshake terms; a command wins over a word in the same cycle
	assign take_w = ce_in && cmd_valid_in && (state_reg == sac_pkg::SAC_IDLE);
	assign push_w = ce_in && word_valid_in && !cmd_valid_in &&
		(state_reg == sac_pkg::SAC_IDLE);
	assign commit_w = ce_in && (state_reg == sac_pkg::SAC_BUSY) &&
		(cnt_reg == 14'h0000);

	// Command decode ignores bit 7, which only steers the request line
	assign op7_w = cmd_in[6:0];
	assign dec_op =
		(op7_w == `SAC_OPC_NOP) ? sac_pkg::SAC_OP_NOP :
		(op7_w == `SAC_OPC_PUSHW) ? sac_pkg::SAC_OP_PUSHW :
		(op7_w == `SAC_OPC_PUSHPI) ? sac_pkg::SAC_OP_PUSHPI :
		(op7_w == `SAC_OPC_POW) ? sac_pkg::SAC_OP_POW :
		(op7_w == `SAC_OPC_ADD) ? sac_pkg::SAC_OP_ADD :
		(op7_w == `SAC_OPC_SUB) ? sac_pkg::SAC_OP_SUB :
		(op7_w == `SAC_OPC_MULL) ? sac_pkg::SAC_OP_MULL :
		(op7_w == `SAC_OPC_MULU) ? sac_pkg::SAC_OP_MULU :
		(op7_w == `SAC_OPC_DIV) ? sac_pkg::SAC_OP_DIV :
		(op7_w == `SAC_OPC_SIN) ? sac_pkg::SAC_OP_SIN :
		(op7_w == `SAC_OPC_TAN) ? sac_pkg::SAC_OP_TAN :
		sac_pkg::SAC_OP_OTHER;

	// Execution length chosen at acceptance from the current operands
	assign dec_cyc =
		(dec_op == sac_pkg::SAC_OP_PUSHW) ? `SAC_CYC_PUSHW :
		(dec_op == sac_pkg::SAC_OP_PUSHPI) ? `SAC_CYC_PUSHPI :
		(dec_op == sac_pkg::SAC_OP_POW) ? POW_CYCLES :
		(dec_op == sac_pkg::SAC_OP_ADD) ? `SAC_CYC_ADD :
		(dec_op == sac_pkg::SAC_OP_SUB) ? `SAC_CYC_SUB :
		(dec_op == sac_pkg::SAC_OP_MULL) ? `SAC_CYC_MULL :
		(dec_op == sac_pkg::SAC_OP_MULU) ? `SAC_CYC_MULU :
		(dec_op == sac_pkg::SAC_OP_DIV) ?
			(int_dz ? `SAC_CYC_DIV0 : `SAC_CYC_DIV) :
		(dec_op == sac_pkg::SAC_OP_SIN) ?
			(flt_tiny ? `SAC_CYC_TINY : SIN_CYCLES) :
		(dec_op == sac_pkg::SAC_OP_TAN) ?
			(flt_tiny ? `SAC_CYC_TINY : TAN_CYCLES) :
		`SAC_CYC_NOP;

	// Integer datapath on the head and second words
	sac_int_unit u_int (
		.a_in(stk_reg[0]),
		.b_in(stk_reg[1]),
		.op_in(op_reg),
		.r_out(int_r),
		.carry_out(int_carry),
		.ovf_out(int_ovf),
		.dz_out(int_dz)
	);

	// Float checks on the two top 32-bit operands
	sac_flt_unit u_flt (
		.a_in({stk_reg[0], stk_reg[1]}),
		.b_in({stk_reg[2], stk_reg[3]}),
		.op_in(op_reg),
		.r_out(flt_r),
		.err_out(flt_err),
		.tiny_out(flt_tiny)
	);

	assign res_hi_w = flt_r[31:16];
	assign res_lo_w = flt_r[15:0];

	// Next stack image; unchanged while a command runs
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			stk_next[i] = stk_reg[i];
		end
		if (push_w) begin
			stk_next[0] = word_in;
			for (int i = 1; i < 8; i++) begin
				stk_next[i] = stk_reg[i - 1];
			end
		end else if (commit_w) begin
			unique case (op_reg)
				sac_pkg::SAC_OP_PUSHW: begin
					for (int i = 1; i < 8; i++) begin
						stk_next[i] = stk_reg[i - 1];
					end
				end
				sac_pkg::SAC_OP_PUSHPI: begin
					stk_next[0] = 16'(`SAC_FP_PI >> 16);
					stk_next[1] = 16'(`SAC_FP_PI);
					for (int i = 2; i < 8; i++) begin
						stk_next[i] = stk_reg[i - 2];
					end
				end
				sac_pkg::SAC_OP_POW: begin
					stk_next[0] = res_hi_w;
					stk_next[1] = res_lo_w;
					for (int i = 2; i < 6; i++) begin
						stk_next[i] = stk_reg[i + 2];
					end
					stk_next[6] = stk_reg[0];
					stk_next[7] = stk_reg[1];
				end
				sac_pkg::SAC_OP_ADD, sac_pkg::SAC_OP_SUB,
				sac_pkg::SAC_OP_MULL, sac_pkg::SAC_OP_MULU,
				sac_pkg::SAC_OP_DIV: begin
					stk_next[0] = int_r;
					for (int i = 1; i < 7; i++) begin
						stk_next[i] = stk_reg[i + 1];
					end
					stk_next[7] = stk_reg[0];
				end
				sac_pkg::SAC_OP_SIN, sac_pkg::SAC_OP_TAN: begin
					stk_next[0] = res_hi_w;
					stk_next[1] = res_lo_w;
				end
				default: begin
					stk_next[0] = stk_reg[0];
				end
			endcase
		end
	end

	// Status image at completion
	always_comb begin
		status_next = status_reg;
		if (commit_w) begin
			unique case (op_reg)
				sac_pkg::SAC_OP_NOP: begin
					status_next = 8'h00;
				end
				sac_pkg::SAC_OP_PUSHW, sac_pkg::SAC_OP_PUSHPI: begin
					status_next[`SAC_ST_SIGN] = stk_next[0][15];
					status_next[`SAC_ST_ZERO] = (stk_next[0] == 16'h0000);
				end
				sac_pkg::SAC_OP_ADD, sac_pkg::SAC_OP_SUB: begin
					status_next[`SAC_ST_SIGN] = int_r[15];
					status_next[`SAC_ST_ZERO] = (int_r == 16'h0000);
					status_next[`SAC_ST_CARRY] = int_carry;
					status_next[`SAC_ST_ERR_HI:`SAC_ST_ERR_LO] =
						int_ovf ? `SAC_ERR_OVF : `SAC_ERR_NONE;
				end
				sac_pkg::SAC_OP_MULL, sac_pkg::SAC_OP_MULU,
				sac_pkg::SAC_OP_DIV: begin
					status_next[`SAC_ST_SIGN] = int_r[15];
					status_next[`SAC_ST_ZERO] = (int_r == 16'h0000);
					status_next[`SAC_ST_ERR_HI:`SAC_ST_ERR_LO] =
						(op_reg == sac_pkg::SAC_OP_DIV && int_dz) ?
						`SAC_ERR_DIV0 :
						(int_ovf ? `SAC_ERR_OVF : `SAC_ERR_NONE);
				end
				sac_pkg::SAC_OP_POW, sac_pkg::SAC_OP_SIN,
				sac_pkg::SAC_OP_TAN: begin
					status_next[`SAC_ST_SIGN] = flt_r[31];
					status_next[`SAC_ST_ZERO] = (flt_r[30:23] == 8'h00);
					status_next[`SAC_ST_ERR_HI:`SAC_ST_ERR_LO] = flt_err;
				end
				default: begin
					status_next = status_reg;
				end
			endcase
		end
	end

	// Stack storage
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < 8; i++) begin
				stk_reg[i] <= 16'h0000;
			end
		end else if (ce_in) begin
			for (int i = 0; i < 8; i++) begin
				stk_reg[i] <= stk_next[i];
			end
		end
	end

	// Sequencer: one command at a time, held for its full count
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_reg <= sac_pkg::SAC_IDLE;
			op_reg <= sac_pkg::SAC_OP_NOP;
			sr_reg <= 1'h0;
			cnt_reg <= 14'h0000;
		end else if (take_w) begin
			state_reg <= sac_pkg::SAC_BUSY;
			op_reg <= dec_op;
			sr_reg <= cmd_in[`SAC_CMD_SR];
			cnt_reg <= dec_cyc - 14'h0001;
		end else if (commit_w) begin
			state_reg <= sac_pkg::SAC_IDLE;
		end else if (ce_in && state_reg == sac_pkg::SAC_BUSY) begin
			cnt_reg <= cnt_reg - 14'h0001;
		end
	end

	// Host-visible flops
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			status_reg <= 8'h00;
			svc_reg <= 1'h0;
			ready_reg <= 1'h0;
			busy_reg <= 1'h0;
		end else if (ce_in) begin
			status_reg <= status_next;
			svc_reg <= commit_w ? sr_reg : svc_reg;
			ready_reg <= !take_w && (commit_w ||
				state_reg == sac_pkg::SAC_IDLE);
			busy_reg <= take_w || (busy_reg && !commit_w);
		end
	end

	assign cmd_ready_out = ready_reg;
	assign busy_out = busy_reg;
	assign stack_head_out = stk_reg[0];
	assign stack_second_out = stk_reg[1];
	assign status_out = status_reg;
	assign svc_req_out = svc_reg;

	// Checking helpers: run length of the current command
	logic [13:0] run_reg;
	logic [13:0] total_reg;
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			run_reg <= 14'h0000;
			total_reg <= 14'h0000;
		end else if (take_w) begin
			run_reg <= 14'h0000;
			total_reg <= dec_cyc;
		end else if (ce_in && busy_reg) begin
			run_reg <= run_reg + 14'h0001;
		end
	end

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	sequence s_commit_op(sac_pkg::sac_op_type o);
		commit_w && op_reg == o;
	endsequence

	sequence s_take_busy;
		take_w ##1 (busy_out && !cmd_ready_out);
	endsequence

	property p_hold_while_busy;
		busy_reg && !commit_w |=> $stable(stack_head_out) &&
			$stable(status_out);
	endproperty
	a_hold_while_busy: assert property (p_hold_while_busy)
		else $error("stack or status moved during execution");

	property p_run_length;
		commit_w |-> run_reg == total_reg - 14'h0001;
	endproperty
	a_run_length: assert property (p_run_length)
		else $error("command finished off its cycle count");

	property p_take_blocks;
		s_take_busy |-> !take_w;
	endproperty
	a_take_blocks: assert property (p_take_blocks)
		else $error("new command taken while busy");

	property p_svc_follow;
		commit_w |=> svc_req_out == $past(sr_reg);
	endproperty
	a_svc_follow: assert property (p_svc_follow)
		else $error("request line does not follow select bit");

	property p_pushw;
		s_commit_op(sac_pkg::SAC_OP_PUSHW) |=>
			stack_head_out == $past(stk_reg[0]) &&
			stack_second_out == $past(stk_reg[0]);
	endproperty
	a_pushw: assert property (p_pushw)
		else $error("word push did not duplicate head");

	property p_pushpi;
		s_commit_op(sac_pkg::SAC_OP_PUSHPI) |=>
			{stack_head_out, stack_second_out} == `SAC_FP_PI &&
			stk_reg[2] == $past(stk_reg[0]);
	endproperty
	a_pushpi: assert property (p_pushpi)
		else $error("pi push wrong");

	property p_add_sum;
		s_commit_op(sac_pkg::SAC_OP_ADD) |=>
			stack_head_out == 16'($past(stk_reg[0]) + $past(stk_reg[1]));
	endproperty
	a_add_sum: assert property (p_add_sum)
		else $error("add result wrong");

	property p_div_zero;
		s_commit_op(sac_pkg::SAC_OP_DIV) and stk_reg[0] == 16'h0000 |=>
			stack_head_out == $past(stk_reg[1]) &&
			status_out[`SAC_ST_ERR_HI:`SAC_ST_ERR_LO] == `SAC_ERR_DIV0;
	endproperty
	a_div_zero: assert property (p_div_zero)
		else $error("zero divisor not handled");

	property p_pow_neg;
		s_commit_op(sac_pkg::SAC_OP_POW) and stk_reg[2][15] |=>
			status_out[`SAC_ST_ERR_HI:`SAC_ST_ERR_LO] == `SAC_ERR_NEG;
	endproperty
	a_pow_neg: assert property (p_pow_neg)
		else $error("negative base not reported");

	property p_mul_min;
		commit_w && (op_reg == sac_pkg::SAC_OP_MULL ||
			op_reg == sac_pkg::SAC_OP_MULU) &&
			stk_reg[0] == `SAC_INT_MIN |=>
			stack_head_out == `SAC_INT_MIN &&
			status_out[`SAC_ST_ERR_HI:`SAC_ST_ERR_LO] == `SAC_ERR_OVF;
	endproperty
	a_mul_min: assert property (p_mul_min)
		else $error("minimum operand multiply wrong");

	property p_tan_tiny;
		take_w && dec_op == sac_pkg::SAC_OP_TAN && flt_tiny |=>
			total_reg == `SAC_CYC_TINY;
	endproperty
	a_tan_tiny: assert property (p_tan_tiny)
		else $error("tiny tangent not short");
endmodule // sac_core

// *** bench/sac_host_model.sv ***
`timescale 1ns/1ps

module sac_host_model (
	// Clock and state seen from the device
	input wire logic clk_in,
	input wire logic cmd_ready_in,
	input wire logic busy_in,
	// Command and operand entry
	output logic cmd_valid_out,
	output logic [7:0] cmd_out,
	output logic word_valid_out,
	output logic [15:0] word_out
);
	// Lines start quiet; released lines later show inverted data
	initial begin
		cmd_valid_out = 1'b0;
		cmd_out = 8'h00;
		word_valid_out = 1'b0;
		word_out = 16'h0000;
	end

	// One operand word, held across exactly one rising edge
	task automatic put_word(input logic [15:0] w);
		@(negedge clk_in);
		word_out = w;
		word_valid_out = 1'b1;
		@(negedge clk_in);
		word_valid_out = 1'b0;
		word_out = ~w; // Released data must not look valid
	endtask

	// Offer a command once idle; n counts edges until busy drops
	task automatic run_cmd(input logic [7:0] c, output int n);
		int k;
		k = 0;
		@(negedge clk_in);
		while (cmd_ready_in !== 1'b1 && k < 100) begin
			@(negedge clk_in);
			k++;
		end
		cmd_out = c;
		cmd_valid_out = 1'b1;
		@(negedge clk_in);
		cmd_valid_out = 1'b0;
		cmd_out = ~c;
		n = 0;
		// Bounded so a stuck sequencer cannot hang the host
		while (busy_in === 1'b1 && n < 20000) begin
			@(negedge clk_in);
			n++;
		end
	endtask
endmodule // sac_host_model

// *** bench/stack_arith_command_set_tb.sv ***
`timescale 1ns/1ps
`include "sac_regs.svh"

module stack_arith_command_set_tb;
	logic clk_in, sys_rst_in, ce_in, cmd_valid, word_valid;
	logic cmd_ready, busy, svc;
	logic [7:0] cmd, status, est, msk;
	logic [15:0] word, head, second, hd;
	logic [31:0] rng;
	logic [15:0] m [8];
	int fail_count, check_count, ecyc, n;
	logic [6:0] ops [5] = '{`SAC_OPC_ADD, `SAC_OPC_SUB, `SAC_OPC_MULL,
		`SAC_OPC_MULU, `SAC_OPC_DIV};
	logic [15:0] bv [9] = '{16'h0001, 16'hffff, 16'h0005, 16'h0001,
		16'h0003, 16'h8000, 16'h0100, 16'h1234, 16'h8001};
	logic [15:0] av [9] = '{16'h7fff, 16'h0001, 16'h8000, 16'h0002,
		16'h8000, 16'h0002, 16'h0100, 16'h0000, 16'h0007};
	logic [7:0] cv [9] = '{8'h6c, 8'hec, 8'h6d, 8'hed, 8'h6e, 8'hf6,
		8'hee, 8'hef, 8'h6f};

	// Short transcendental counts keep the run brief
	sac_core #(.POW_CYCLES(14'h0028), .SIN_CYCLES(14'h002c),
		.TAN_CYCLES(14'h0030)) u_sac_core (.clk_in(clk_in),
		.sys_rst_in(sys_rst_in), .ce_in(ce_in), .cmd_valid_in(cmd_valid),
		.cmd_in(cmd), .word_valid_in(word_valid), .word_in(word),
		.cmd_ready_out(cmd_ready), .busy_out(busy),
		.stack_head_out(head), .stack_second_out(second),
		.status_out(status), .svc_req_out(svc));

	sac_host_model u_sac_host_model (.clk_in(clk_in),
		.cmd_ready_in(cmd_ready), .busy_in(busy), .cmd_valid_out(cmd_valid),
		.cmd_out(cmd), .word_valid_out(word_valid), .word_out(word));

	// Free-running 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end

	// Xorshift source so the operand mix is repeatable
	function automatic logic [15:0] rnd();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng[15:0];
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Model and device both take the word onto the head
	task automatic push(input logic [15:0] w);
		for (int i = 7; i > 0; i--) m[i] = m[i - 1];
		m[0] = w;
		u_sac_host_model.put_word(w);
		check(32'(head), 32'(w));
	endtask

	// Floats go in lower word first so the upper half ends at the head
	task automatic pushf(input logic [31:0] f);
		push(f[15:0]);
		push(f[31:16]);
	endtask

	// Reference model of one command, then compare with the device
	task automatic do_cmd(input logic [7:0] c);
		logic [15:0] a, b, r;
		logic [31:0] p, fa, fb, fr;
		logic [16:0] t;
		logic [6:0] cr;
		int s;
		logic cy, ov, bin, fl, nop, unk, chk;
		logic [3:0] er;
		a = m[0];
		b = m[1];
		fa = {m[0], m[1]};
		fb = {m[2], m[3]};
		cr = c[6:0];
		p = $signed(a) * $signed(b);
		{cy, ov, bin, fl, nop, unk, chk} = 7'b0000001;
		er = 4'h0;
		r = a;
		msk = 8'hff;
		ecyc = 4;
		case (cr)
		`SAC_OPC_ADD: begin
			t = a + b;
			s = $signed(a) + $signed(b);
			{r, cy, bin, ecyc} = {s[15:0], t[16], 1'b1, 32'd18};
			ov = s > 32767 || s < -32768;
		end
		`SAC_OPC_SUB: begin
			s = $signed(b) - $signed(a);
			{r, cy, bin, ecyc} = {s[15:0], b < a, 1'b1, 32'd32};
			ov = a == 16'h8000 || s > 32767 || s < -32768;
		end
		`SAC_OPC_MULL, `SAC_OPC_MULU: begin
			r = (cr == `SAC_OPC_MULL) ? p[15:0] : p[31:16];
			ov = cr == `SAC_OPC_MULL && p[31:16] != 16'h0000;
			if (a == 16'h8000 || b == 16'h8000) {r, ov} = {16'h8000, 1'b1};
			ecyc = (cr == `SAC_OPC_MULL) ? 94 : 98;
			{msk, bin} = {8'hde, 1'b1};
		end
		`SAC_OPC_DIV: begin
			{msk, bin} = {8'hde, 1'b1};
			if (a == 16'h0000) {r, er, ecyc} = {b, 4'h8, 32'd14};
			else {r, ecyc} = {16'($signed(b) / $signed(a)), 32'd94};
		end
		`SAC_OPC_PUSHW: begin
			for (int i = 7; i > 0; i--) m[i] = m[i - 1];
			{msk, ecyc} = {8'hc0, 32'd16};
		end
		`SAC_OPC_PUSHPI: begin
			for (int i = 7; i > 1; i--) m[i] = m[i - 2];
			{m[0], m[1], msk, ecyc, fl} = {32'h40490fdb, 8'hc0, 32'd16, 1'b1};
		end
		`SAC_OPC_SIN, `SAC_OPC_TAN: begin
			{msk, fl} = {8'hde, 1'b1};
			ecyc = (cr == `SAC_OPC_SIN) ? 44 : 48;
			if (fa[30:23] < 8'h73) ecyc = 30;
			ov = cr == `SAC_OPC_TAN && fa == `SAC_FP_HALF_PI;
		end
		`SAC_OPC_POW: begin
			{ecyc, fl} = {32'd40, 1'b1};
			if (fb[31] || fb[30:0] == 31'h0) er = 4'h4;
			else if (fa[30:23] >= 8'h84) er = 4'hc;
			fr = (fa[30:0] == 31'h0) ? `SAC_FP_ONE : fb;
			{m[0], m[1], m[2], m[3]} = {fr, m[4], m[5]};
			chk = er == 4'h0;
			msk = chk ? 8'hde : 8'h1e;
		end
		default: {nop, unk} = {cr == `SAC_OPC_NOP, cr != `SAC_OPC_NOP};
		endcase
		er = ov ? 4'h6 : er;
		if (bin) begin
			for (int i = 1; i < 7; i++) m[i] = m[i + 1];
			{m[0], m[7]} = {r, a};
		end
		// Unknown codes leave the status as the previous command left it
		if (!unk) est = {m[0][15], fl ? ({m[0], m[1]} << 1) == 0 :
			m[0] == 0, 1'b0, er, cy};
		if (nop) est = 8'h00;
		u_sac_host_model.run_cmd(c, n);
		check(32'(n), 32'(ecyc));
		if (chk) check({head, second}, {m[0], m[1]});
		check(32'(status & msk), 32'(est & msk));
		check(32'(svc), 32'(c[7]));
	endtask

	// Watchdog: the whole sequence needs well under 20000 cycles
	initial begin
		#300000;
		fail_count++;
		test_done();
	end

	// Main sequence
	initial begin
		{fail_count, check_count, rng} = {32'd0, 32'd0, 32'hdd49};
		{sys_rst_in, ce_in} = 2'b11;
		for (int i = 0; i < 8; i++) m[i] = 16'h0000;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		sys_rst_in = 1'b0;
		check({head, second}, 32'h0);
		check(32'({status, svc, busy, cmd_ready}), 32'h0);
		do_cmd(8'h80);
		do_cmd(8'h00);
		do_cmd(8'hff);
		for (int i = 0; i < 15; i++) begin
			push(rnd());
			push(rnd());
			hd = rnd();
			do_cmd({hd[7], ops[i % 5]});
		end
		for (int i = 0; i < 9; i++) begin
			push(bv[i]);
			push(av[i]);
			do_cmd(cv[i]);
		end
		// A word offered mid-command is refused and the stack holds
		push(16'h0003);
		push(16'h0002);
		fork
			do_cmd(8'hef);
			begin
				repeat (4) @(negedge clk_in);
				u_sac_host_model.put_word(16'h1234);
				check(32'({head, cmd_ready}), 32'({16'h0002, 1'b0}));
			end
		join
		// Enable low freezes the stack, so an offered word is dropped
		ce_in = 1'b0;
		u_sac_host_model.put_word(rnd());
		check(32'(head), 32'(m[0]));
		ce_in = 1'b1;
		do_cmd(8'hf7);
		do_cmd(8'h77);
		do_cmd(8'h9a);
		do_cmd(8'h1a);
		pushf(32'h38000000);
		do_cmd(8'h82);
		pushf(32'h3f000000);
		do_cmd(8'h02);
		pushf(32'hb8800000);
		do_cmd(8'h84);
		pushf(`SAC_FP_HALF_PI);
		do_cmd(8'h04);
		pushf(32'h40400000);
		pushf(32'h40000000);
		do_cmd(8'h0b);
		pushf(32'hc0000000);
		pushf(32'h40000000);
		do_cmd(8'h0b);
		pushf(32'h40400000);
		pushf(32'h42000000);
		do_cmd(8'h0b);
		test_done();
	end
endmodule // stack_arith_command_set_tb
